// ==== design/sccp_pkg.sv ====
// package: register map, field layouts and types of the six-channel capture/compare timer
package sccp_pkg;
   // ==========================================================
   // register byte offsets (one aligned 32-bit word each)
   localparam logic [7:0] SCCP_OFF_CTRL = 8'h00;
   localparam logic [7:0] SCCP_OFF_MOD = 8'h04;
   localparam logic [7:0] SCCP_OFF_CNT = 8'h08;
   localparam logic [7:0] SCCP_OFF_SC_BASE = 8'h10;
   localparam logic [7:0] SCCP_SC_STRIDE = 8'h04;
   localparam logic [7:0] SCCP_OFF_VAL_BASE = 8'h40;
   localparam logic [7:0] SCCP_VAL_STRIDE = 8'h08;
   localparam logic [7:0] SCCP_VAL_LO_OFS = 8'h04;
   // ==========================================================
   // control word field positions
   localparam int SCCP_CTRL_RATE_LSB = 0;
   localparam int SCCP_CTRL_STOP_BIT = 4;
   localparam int SCCP_CTRL_CRST_BIT = 5;
   localparam int SCCP_CTRL_OVF_BIT = 7;
   // channel status/control field positions
   localparam int SCCP_SC_FLAG_BIT = 7;
   localparam int SCCP_SC_IE_BIT = 6;
   // ==========================================================
   // reset values and counts
   localparam logic [2:0] SCCP_RATE_RST = 3'h0;
   localparam logic [2:0] SCCP_RATE_EXT = 3'h7;
   localparam logic [15:0] SCCP_MOD_RST = 16'hffff;
   localparam logic SCCP_STOP_RST = 1'b0;
   localparam int SCCP_NUM_CH = 6;
   localparam int SCCP_DIV_W = 6;
   // ==========================================================
   // edge/level select codes
   localparam logic [1:0] SCCP_ELS_OFF = 2'h0;
   localparam logic [1:0] SCCP_ELS_RISE_TGL = 2'h1;
   localparam logic [1:0] SCCP_ELS_FALL_CLR = 2'h2;
   localparam logic [1:0] SCCP_ELS_BOTH_SET = 2'h3;

   // per-channel status/control bits, in register bit order 7..1
   typedef struct packed {
      logic flag;
      logic ie;
      logic buf_mode;
      logic mode_select_lo;
      logic edge_level_sel_hi;
      logic edge_level_sel_lo;
      logic overflow_toggle_enable;
   } sccp_chan_ctrl_t;

   // apb request bundle
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } sccp_apb_req_t;
endpackage

// ==== design/sccp_timer.sv ====
// six-channel capture/compare/pwm timer with apb register access
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/100ps

// Functional notes
// - counter clock from seven bus-clock divides or the channel-0 pin, via 3-bit select
// - all channels capture and compare against one common 16-bit counter
// - each channel value is held as high and low 8-bit halves
// - input capture copies the counter into the channel value on the active edge
// - capture edge polarity chosen per channel by two edge/level select bits
// - every qualifying edge overwrites the value regardless of the event flag
// - a set event flag with its enable on raises the interrupt; polling also works
// - reset leaves channel values untouched
// - on compare match the pin is set, cleared or toggled as configured
// - a compare match sets the event flag and may request an interrupt
// - unbuffered compare uses a new value at once; a compare may be skipped
// - buffer bit on channel 0, 2 or 4 links the odd partner; output on even pin
// - even value rules first; last-written channel takes over at each overflow
// - linked odd channel control is unused and its pin is released
// - toggle-on-overflow flips the pin as the counter wraps from the modulo back to zero
// - high select bit alone clears on compare (positive pulse), both bits set (negative)
// - modulo 255 at the fastest rate gives a 256-clock period
// - duty equals channel value over period count
// - mode bits 0:1 unbuffered, 1:0 buffered; high bit wins over low
// - clearing toggle-on-overflow stops overflow toggles, giving zero duty when the pin clears on compare
module sccp_timer #(
   parameter int CHANNELS = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire sccp_pkg::sccp_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CHANNELS-1:0] chan_pin_in,
   output logic [CHANNELS-1:0] chan_pin_out,
   output logic [CHANNELS-1:0] chan_pin_oe,
   output logic irq
);
   import sccp_pkg::*;

   // ==========================================================
   // elaboration check
   if (CHANNELS != SCCP_NUM_CH) begin : g_bad_channels
      $error("sccp_timer serves exactly six channels");
   end

   // ==========================================================
   // helpers
   // index of a status/control word, or CHANNELS when the address is not one
   function automatic int sc_index(input logic [7:0] addr);
      int idx;
      idx = CHANNELS;
      for (int i = 0; i < CHANNELS; i++) begin
         if (addr == 8'(SCCP_OFF_SC_BASE + 8'(i) * SCCP_SC_STRIDE)) begin
            idx = i;
         end
      end
      return idx;
   endfunction

   // index of a value half; lo_half tells which half was addressed
   function automatic int val_index(input logic [7:0] addr, input logic lo_half);
      int idx;
      logic [7:0] ofs;
      idx = CHANNELS;
      ofs = lo_half ? SCCP_VAL_LO_OFS : 8'h00;
      for (int i = 0; i < CHANNELS; i++) begin
         if (addr == 8'(SCCP_OFF_VAL_BASE + 8'(i) * SCCP_VAL_STRIDE + ofs)) begin
            idx = i;
         end
      end
      return idx;
   endfunction

   // ==========================================================
   // state
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff;
   logic [2:0] clock_rate_select_ff;
   logic stop_ff, ovf_flag_ff;
   logic [15:0] modulo_ff, count_ff;
   logic [SCCP_DIV_W-1:0] div_ff;
   logic [CHANNELS-1:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
   sccp_chan_ctrl_t [CHANNELS-1:0] ctrl_ff;
   logic [CHANNELS-1:0][15:0] value_ff;
   logic [CHANNELS-1:0] pin_ff, oe_ff;
   logic [2:0] use_odd_ff, next_odd_ff;
   logic irq_ff;

   // ==========================================================
   // bus decode
   logic wr_en, crst_req;
   int wr_sc, wr_hi, wr_lo, rd_sc, rd_hi, rd_lo;
   logic [7:0] wbyte;
   logic mapped;

   // a write lands only on the access-phase edge where pready is high
   assign wr_en = apb_req.psel & apb_req.penable & pready_ff & apb_req.pwrite;
   assign wbyte = apb_req.pwdata[7:0];
   assign wr_sc = wr_en ? sc_index(apb_req.paddr) : CHANNELS;
   assign wr_hi = wr_en ? val_index(apb_req.paddr, 1'b0) : CHANNELS;
   assign wr_lo = wr_en ? val_index(apb_req.paddr, 1'b1) : CHANNELS;
   assign rd_sc = sc_index(apb_req.paddr);
   assign rd_hi = val_index(apb_req.paddr, 1'b0);
   assign rd_lo = val_index(apb_req.paddr, 1'b1);
   assign crst_req = wr_en & (apb_req.paddr == SCCP_OFF_CTRL) & apb_req.pwdata[SCCP_CTRL_CRST_BIT];
   assign mapped = (apb_req.paddr == SCCP_OFF_CTRL) | (apb_req.paddr == SCCP_OFF_MOD) |
                   (apb_req.paddr == SCCP_OFF_CNT) | (rd_sc < CHANNELS) |
                   (rd_hi < CHANNELS) | (rd_lo < CHANNELS);

   // ==========================================================
   // pin synchronisers: the first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
         pin_prev_ff <= '0;
      end else begin
         pin_meta_ff <= chan_pin_in;
         pin_sync_ff <= pin_meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end

   // ==========================================================
   // prescaler and counter clock select
   logic [SCCP_DIV_W-1:0] div_mask;
   logic ext_rise, tick, ovf;
   logic [15:0] nxt_count;

   assign div_mask = SCCP_DIV_W'((7'h01 << clock_rate_select_ff) - 7'h01);
   assign ext_rise = pin_sync_ff[0] & ~pin_prev_ff[0];
   // select 7 counts on rising edges of the channel-0 pin, others divide by 1..64
   assign tick = ~stop_ff & ((clock_rate_select_ff == SCCP_RATE_EXT) ? ext_rise :
                 ((div_ff & div_mask) == div_mask));
   assign ovf = tick & (count_ff == modulo_ff);
   // compare fires as the counter arrives at the value, so a pulse opened by
   // an overflow lasts exactly value ticks and a value of zero gives zero duty
   assign nxt_count = ovf ? 16'h0000 : count_ff + 16'h0001;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= '0;
      end else if (crst_req) begin
         div_ff <= '0;
      end else if (!stop_ff) begin
         div_ff <= div_ff + 1'b1;
      end
   end

   // shared 16-bit counter: up from zero, wraps after reaching the modulo
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= '0;
      end else if (crst_req) begin
         count_ff <= '0;
      end else if (ovf) begin
         count_ff <= '0;
      end else if (tick) begin
         count_ff <= count_ff + 16'h0001;
      end
   end

   // ==========================================================
   // global control: rate select, stop, modulo, overflow flag (write 1 to clear)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_rate_select_ff <= SCCP_RATE_RST;
         stop_ff <= SCCP_STOP_RST;
         modulo_ff <= SCCP_MOD_RST;
         ovf_flag_ff <= 1'b0;
      end else begin
         if (wr_en && apb_req.paddr == SCCP_OFF_CTRL) begin
            clock_rate_select_ff <= apb_req.pwdata[SCCP_CTRL_RATE_LSB +: 3];
            stop_ff <= apb_req.pwdata[SCCP_CTRL_STOP_BIT];
         end
         if (wr_en && apb_req.paddr == SCCP_OFF_MOD) begin
            modulo_ff <= apb_req.pwdata[15:0];
         end
         // set beats clear so an overflow in the clearing cycle survives
         if (ovf) begin
            ovf_flag_ff <= 1'b1;
         end else if (wr_en && apb_req.paddr == SCCP_OFF_CTRL &&
                      apb_req.pwdata[SCCP_CTRL_OVF_BIT]) begin
            ovf_flag_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // per-channel mode decode
   logic [CHANNELS-1:0] linked_even, released_odd, oc_mode, ic_mode, cap_evt, cmp_evt;
   logic [CHANNELS-1:0][15:0] cmp_val;
   logic [CHANNELS-1:0][1:0] els;

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         els[i] = {ctrl_ff[i].edge_level_sel_hi, ctrl_ff[i].edge_level_sel_lo};
         // buffer bit exists only on even channels and overrides the low mode bit
         linked_even[i] = (i % 2 == 0) && ctrl_ff[i].buf_mode;
         released_odd[i] = (i % 2 == 1) && ctrl_ff[i - (i % 2)].buf_mode;
         oc_mode[i] = ~released_odd[i] & (linked_even[i] | ctrl_ff[i].mode_select_lo);
         ic_mode[i] = ~released_odd[i] & ~oc_mode[i];
         // linked pair compares against whichever half is in charge this period
         if (linked_even[i] && use_odd_ff[i/2]) begin
            cmp_val[i] = value_ff[(i+1) % CHANNELS];
         end else begin
            cmp_val[i] = value_ff[i];
         end
         cmp_evt[i] = oc_mode[i] & tick & (nxt_count == cmp_val[i]);
         unique case (els[i])
            SCCP_ELS_RISE_TGL: cap_evt[i] = pin_sync_ff[i] & ~pin_prev_ff[i];
            SCCP_ELS_FALL_CLR: cap_evt[i] = ~pin_sync_ff[i] & pin_prev_ff[i];
            SCCP_ELS_BOTH_SET: cap_evt[i] = pin_sync_ff[i] ^ pin_prev_ff[i];
            SCCP_ELS_OFF: cap_evt[i] = 1'b0;
         endcase
         cap_evt[i] = cap_evt[i] & ic_mode[i];
      end
   end

   // ==========================================================
   // channel status/control registers; flags are write-1-to-clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (wr_sc == i) begin
               ctrl_ff[i].ie <= wbyte[SCCP_SC_IE_BIT];
               ctrl_ff[i].buf_mode <= (i % 2 == 0) ? wbyte[5] : 1'b0;
               ctrl_ff[i].mode_select_lo <= wbyte[4];
               ctrl_ff[i].edge_level_sel_hi <= wbyte[3];
               ctrl_ff[i].edge_level_sel_lo <= wbyte[2];
               ctrl_ff[i].overflow_toggle_enable <= wbyte[1];
            end
            if (cap_evt[i] || cmp_evt[i]) begin
               ctrl_ff[i].flag <= 1'b1;
            end else if (wr_sc == i && wbyte[SCCP_SC_FLAG_BIT]) begin
               ctrl_ff[i].flag <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // channel values: no reset on purpose, content survives a system reset
   always_ff @(posedge pclk) begin
      for (int i = 0; i < CHANNELS; i++) begin
         if (cap_evt[i]) begin
            value_ff[i] <= count_ff;
         end else begin
            if (wr_hi == i) begin
               value_ff[i][15:8] <= wbyte;
            end
            if (wr_lo == i) begin
               value_ff[i][7:0] <= wbyte;
            end
         end
      end
   end

   // ==========================================================
   // buffered pairs: remember last-written half, hand over at overflow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         use_odd_ff <= '0;
         next_odd_ff <= '0;
      end else begin
         for (int p = 0; p < CHANNELS / 2; p++) begin
            if (!ctrl_ff[2*p].buf_mode) begin
               // unlinked: even channel takes charge first when linking starts
               use_odd_ff[p] <= 1'b0;
               next_odd_ff[p] <= 1'b0;
            end else begin
               if (wr_hi == 2*p+1 || wr_lo == 2*p+1) begin
                  next_odd_ff[p] <= 1'b1;
               end else if (wr_hi == 2*p || wr_lo == 2*p) begin
                  next_odd_ff[p] <= 1'b0;
               end
               if (ovf) begin
                  use_odd_ff[p] <= next_odd_ff[p];
               end
            end
         end
      end
   end

   // ==========================================================
   // pin drive: a compare action in the same tick as an overflow replaces the overflow toggle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_ff <= '0;
         oe_ff <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            // linked odd pins are released to general-purpose use
            oe_ff[i] <= oc_mode[i] & (els[i] != SCCP_ELS_OFF);
            if (cmp_evt[i]) begin
               unique case (els[i])
                  SCCP_ELS_RISE_TGL: pin_ff[i] <= ~pin_ff[i];
                  SCCP_ELS_FALL_CLR: pin_ff[i] <= 1'b0;
                  SCCP_ELS_BOTH_SET: pin_ff[i] <= 1'b1;
                  SCCP_ELS_OFF: pin_ff[i] <= pin_ff[i];
               endcase
            end else if (ovf && oc_mode[i] && ctrl_ff[i].overflow_toggle_enable) begin
               pin_ff[i] <= ~pin_ff[i];
            end
         end
      end
   end

   // ==========================================================
   // interrupt request from any enabled channel flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= 1'b0;
         for (int i = 0; i < CHANNELS; i++) begin
            if (ctrl_ff[i].flag && ctrl_ff[i].ie) begin
               irq_ff <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // apb answer: zero wait states, pready raised for the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= '0;
      end else begin
         pready_ff <= apb_req.psel & ~apb_req.penable & ~pready_ff;
         pslverr_ff <= apb_req.psel & ~apb_req.penable & ~pready_ff & ~mapped;
         prdata_ff <= '0;
         if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            if (apb_req.paddr == SCCP_OFF_CTRL) begin
               prdata_ff <= {24'h000000, ovf_flag_ff, 2'h0, stop_ff, 1'b0, clock_rate_select_ff};
            end else if (apb_req.paddr == SCCP_OFF_MOD) begin
               prdata_ff <= {16'h0000, modulo_ff};
            end else if (apb_req.paddr == SCCP_OFF_CNT) begin
               prdata_ff <= {16'h0000, count_ff};
            end else if (rd_sc < CHANNELS) begin
               prdata_ff <= {24'h000000, ctrl_ff[rd_sc], 1'b0};
            end else if (rd_hi < CHANNELS) begin
               prdata_ff <= {24'h000000, value_ff[rd_hi][15:8]};
            end else if (rd_lo < CHANNELS) begin
               prdata_ff <= {24'h000000, value_ff[rd_lo][7:0]};
            end
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign chan_pin_out = pin_ff;
   assign chan_pin_oe = oe_ff;
   assign irq = irq_ff;
endmodule

// ==== test/sccp_timer_sva.sv ====
// concurrent checks on the ports of the capture/compare timer
`timescale 1ns/100ps
module sccp_timer_sva #(
   parameter int CHANNELS = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire sccp_pkg::sccp_apb_req_t apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [CHANNELS-1:0] chan_pin_in,
   input wire logic [CHANNELS-1:0] chan_pin_out,
   input wire logic [CHANNELS-1:0] chan_pin_oe,
   input wire logic irq
);
   import sccp_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ==========================================================
   // bus handshake
   logic wr_done;
   // a completed write is the only thing that may reconfigure pins or clear flags
   assign wr_done = pready && apb_req.psel && apb_req.pwrite;
   property p_ready_after_setup;
      apb_req.psel && !apb_req.penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
   property p_ready_single;
      pready |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single) else $error("ready held too long");
   property p_ready_in_access;
      pready |-> apb_req.psel && apb_req.penable;
   endproperty
   a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
   property p_err_with_ready;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("bad error response");
   property p_idle_no_ready;
      !apb_req.psel |=> !pready;
   endproperty
   a_idle_no_ready: assert property (p_idle_no_ready) else $error("ready while idle");
   property p_ready_cause;
      $rose(pready) |-> $past(apb_req.psel && !apb_req.penable);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
   // ==========================================================
   // pins and interrupt
   property p_oe_by_write;
      $changed(chan_pin_oe) |-> $past(wr_done) || $past(wr_done, 2);
   endproperty
   a_oe_by_write: assert property (p_oe_by_write) else $error("pin enable moved alone");
   property p_irq_fall_by_write;
      $fell(irq) |-> $past(wr_done) || $past(wr_done, 2);
   endproperty
   a_irq_fall_by_write: assert property (p_irq_fall_by_write) else $error("irq fell alone");
endmodule

// ==== test/sccp_pin_model.sv ====
// outside world on the channel pins: static levels plus an external count clock
`timescale 1ns/100ps
module sccp_pin_model (
   input wire logic pclk,
   input wire logic [5:0] pin_lvl,
   input wire logic ext_run,
   output logic [5:0] chan_pin_in
);
   logic [1:0] div_ff;
   logic ext_ff;
   // count clock toggles every fourth bus clock, only while a burst is requested
   always_ff @(posedge pclk) begin
      if (!ext_run) begin
         div_ff <= 2'h0;
         ext_ff <= 1'b0;
      end else begin
         div_ff <= div_ff + 2'h1;
         if (div_ff == 2'h3) begin
            ext_ff <= !ext_ff;
         end
      end
   end
   // channel zero carries the count clock during a burst, else its plain level
   assign chan_pin_in = {pin_lvl[5:1], ext_run ? ext_ff : pin_lvl[0]};
endmodule

// ==== test/sccp_timer_tb.sv ====
// self-checking bench for the six-channel capture/compare timer
`timescale 1ns/100ps
module sccp_timer_tb;
   import sccp_pkg::*;
   logic pclk;
   logic presetn;
   sccp_apb_req_t apb_req;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [5:0] pin_lvl;
   logic ext_run;
   logic [5:0] chan_pin_in;
   logic [5:0] chan_pin_out;
   logic [5:0] chan_pin_oe;
   logic irq;
   int fails;
   int n_compared;
   logic [31:0] rd;
   logic [31:0] c1;
   logic [15:0] v;
   logic err;
   int hi;
   int per;

   sccp_timer #(.CHANNELS(6)) sccp_timer_inst (.pclk(pclk), .presetn(presetn),
      .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
      .irq(irq));
   sccp_pin_model sccp_pin_model_inst (.pclk(pclk), .pin_lvl(pin_lvl), .ext_run(ext_run),
      .chan_pin_in(chan_pin_in));

   // 200 MHz bus clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = !pclk;
   end

   // ==========================================================
   // reporting
   task automatic test_done();
      if (fails == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic hang(input string nm);
      fails++;
      $display("Error %s expected completion seen timeout", nm);
      test_done();
   endtask
   // ==========================================================
   // bus access: setup, then access held until ready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang("pready");
      rd = prdata;
      err = pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask
   function automatic logic [7:0] sc_a(input int n);
      return SCCP_OFF_SC_BASE + SCCP_SC_STRIDE * 8'(n);
   endfunction
   function automatic logic [7:0] vh_a(input int n);
      return SCCP_OFF_VAL_BASE + SCCP_VAL_STRIDE * 8'(n);
   endfunction
   // value halves live in separate words, high first
   task automatic setval(input int n, input logic [15:0] val);
      wr(vh_a(n), {24'h0, val[15:8]});
      wr(vh_a(n) + SCCP_VAL_LO_OFS, {24'h0, val[7:0]});
   endtask
   task automatic rdv(input int n);
      apb(1'b0, vh_a(n), 32'h0);
      v[15:8] = rd[7:0];
      apb(1'b0, vh_a(n) + SCCP_VAL_LO_OFS, 32'h0);
      v[7:0] = rd[7:0];
   endtask
   // width of the pol phase and full period, from a clean edge onward
   task automatic measure(input int ch, input logic pol);
      int n;
      n = 0;
      do begin @(posedge pclk); n++; end while (chan_pin_out[ch] === pol && n < 3000);
      do begin @(posedge pclk); n++; end while (chan_pin_out[ch] !== pol && n < 3000);
      hi = 0;
      do begin @(posedge pclk); hi++; end while (chan_pin_out[ch] === pol && hi < 3000);
      per = hi;
      do begin @(posedge pclk); per++; end while (chan_pin_out[ch] !== pol && per < 3000);
      if (n >= 3000 || per >= 3000) hang("pwm edge");
   endtask

   // ==========================================================
   // main sequence
   initial begin
      presetn = 1'b0;
      apb_req = '0;
      pin_lvl = 6'h0;
      ext_run = 1'b0;
      fails = 0;
      n_compared = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, unmapped address, free counting
      rdc("mod_rst", SCCP_OFF_MOD, {16'h0, SCCP_MOD_RST});
      rdc("ctrl_rst", SCCP_OFF_CTRL, 32'h0);
      apb(1'b0, 8'hfc, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_data", 32'h0, rd);
      apb(1'b0, SCCP_OFF_CNT, 32'h0);
      c1 = rd;
      apb(1'b0, SCCP_OFF_CNT, 32'h0);
      chk("cnt_up", 32'h1, {31'h0, rd > c1});
      // positive pwm on channel 2 at three prescaler rates
      wr(SCCP_OFF_CTRL, 32'h10);
      wr(SCCP_OFF_MOD, 32'hff);
      setval(2, 16'h0080);
      wr(sc_a(2), 32'h1a);
      for (int r = 0; r < 3; r++) begin
         wr(SCCP_OFF_CTRL, 32'h20 | 32'(r));
         measure(2, 1'b1);
         chk("pwm_period", 32'(256 << r), 32'(per));
         chk("pwm_width", 32'(128 << r), 32'(hi));
      end
      rdc("cmp_flag", sc_a(2), 32'h9a);
      // negative pulse by setting on compare, still at divide by four
      wr(sc_a(2), 32'h1e);
      measure(2, 1'b0);
      chk("pwm_neg_width", 32'd512, 32'(hi));
      // no overflow toggle leaves the pin low
      wr(sc_a(2), 32'h18);
      repeat (1100) @(posedge pclk);
      hi = 0;
      repeat (1100) begin
         @(posedge pclk);
         if (chan_pin_out[2] !== 1'b0) hi++;
      end
      chk("no_tov_high", 32'h0, 32'(hi));
      // buffered pair 4/5: even value first, odd after the next overflow
      wr(SCCP_OFF_CTRL, 32'h20);
      setval(4, 16'h0040);
      wr(sc_a(4), 32'h2a);
      measure(4, 1'b1);
      chk("buf_first", 32'd64, 32'(hi));
      setval(5, 16'h00c0);
      measure(4, 1'b1);
      chk("buf_second", 32'd192, 32'(hi));
      chk("odd_released", 32'h0, {31'h0, chan_pin_oe[5]});
      chk("even_driven", 32'h1, {31'h0, chan_pin_oe[4]});
      // rising-edge capture on channel 1 with a stopped counter
      wr(sc_a(1), 32'h44);
      wr(SCCP_OFF_CTRL, 32'h10);
      apb(1'b0, SCCP_OFF_CNT, 32'h0);
      c1 = rd;
      pin_lvl[1] <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("irq_cap", 32'h1, {31'h0, irq});
      rdv(1);
      chk("cap_val", c1, {16'h0, v});
      // second capture with the flag still set overwrites the value
      wr(SCCP_OFF_CTRL, 32'h0);
      wr(SCCP_OFF_CTRL, 32'h10);
      apb(1'b0, SCCP_OFF_CNT, 32'h0);
      c1 = rd;
      pin_lvl[1] <= 1'b0;
      repeat (4) @(posedge pclk);
      pin_lvl[1] <= 1'b1;
      repeat (8) @(posedge pclk);
      rdv(1);
      chk("cap_over", c1, {16'h0, v});
      rdc("cap_flag", sc_a(1), 32'hc4);
      wr(sc_a(1), 32'hc4);
      repeat (4) @(posedge pclk);
      chk("irq_clear", 32'h0, {31'h0, irq});
      // falling-only capture ignores a rising edge
      wr(sc_a(3), 32'h08);
      pin_lvl[3] <= 1'b1;
      repeat (8) @(posedge pclk);
      rdc("rise_ignored", sc_a(3), 32'h08);
      pin_lvl[3] <= 1'b0;
      repeat (8) @(posedge pclk);
      rdc("fall_seen", sc_a(3), 32'h88);
      // counter clocked by ten rising edges on channel 0
      wr(SCCP_OFF_CTRL, {24'h0, 5'h04, SCCP_RATE_EXT});
      ext_run <= 1'b1;
      repeat (80) @(posedge pclk);
      ext_run <= 1'b0;
      repeat (8) @(posedge pclk);
      rdc("ext_count", SCCP_OFF_CNT, 32'ha);
      test_done();
   end
endmodule

bind sccp_timer sccp_timer_sva #(.CHANNELS(CHANNELS)) sccp_timer_sva_inst (.pclk(pclk),
   .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
   .irq(irq));
